// *** verilog/asctl_pkg.sv ***
`default_nettype none
package asctl_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_START_TASK    = 12'h000;
  localparam logic [11:0] OFS_STOP_TASK     = 12'h004;
  localparam logic [11:0] OFS_START_LINK    = 12'h080;
  localparam logic [11:0] OFS_STOP_LINK     = 12'h084;
  localparam logic [11:0] OFS_RX_UPD_FLAG   = 12'h104;
  localparam logic [11:0] OFS_STOPPED_FLAG  = 12'h108;
  localparam logic [11:0] OFS_TX_UPD_FLAG   = 12'h114;
  localparam logic [11:0] OFS_RX_UPD_BCAST  = 12'h184;
  localparam logic [11:0] OFS_STOPPED_BCAST = 12'h188;
  localparam logic [11:0] OFS_TX_UPD_BCAST  = 12'h194;
  localparam logic [11:0] OFS_IRQ_ENABLE    = 12'h300;
  localparam logic [11:0] OFS_IRQ_SET       = 12'h304;
  localparam logic [11:0] OFS_IRQ_CLEAR     = 12'h308;
  localparam logic [11:0] OFS_UNIT_ENABLE   = 12'h500;
  localparam logic [11:0] OFS_ROLE          = 12'h504;
  localparam logic [11:0] OFS_RX_ENABLE     = 12'h508;
  localparam logic [11:0] OFS_TX_ENABLE     = 12'h50C;
  localparam logic [11:0] OFS_MCK_ENABLE    = 12'h510;
  localparam logic [11:0] OFS_MCK_DIVIDER   = 12'h514;
  localparam logic [11:0] OFS_RATIO         = 12'h518;
  localparam logic [11:0] OFS_SWIDTH        = 12'h51C;
  localparam logic [11:0] OFS_ALIGN         = 12'h520;
  localparam logic [11:0] OFS_FORMAT        = 12'h524;
  localparam logic [11:0] OFS_CHANNELS      = 12'h528;
  localparam logic [11:0] OFS_RX_PTR        = 12'h538;
  localparam logic [11:0] OFS_TX_PTR        = 12'h540;
  localparam logic [11:0] OFS_WORD_COUNT    = 12'h550;
  localparam logic [11:0] OFS_PIN_MCK       = 12'h560;
  localparam logic [11:0] OFS_PIN_BCK       = 12'h564;
  localparam logic [11:0] OFS_PIN_FCK       = 12'h568;
  localparam logic [11:0] OFS_PIN_SIN       = 12'h56C;
  localparam logic [11:0] OFS_PIN_SOUT      = 12'h570;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int LINK_EN_BIT  = 31;
  localparam int LINK_CH_W    = 4;
  localparam int IRQ_RX_BIT   = 1;
  localparam int IRQ_STOP_BIT = 2;
  localparam int IRQ_TX_BIT   = 5;
  localparam int PIN_CONN_BIT = 31;
  localparam int PIN_NUM_W    = 5;
  localparam int NUM_CHAN     = 16;
  localparam int NUM_PINS     = 32;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
  localparam logic [31:0] RST_TX_EN   = 32'h0000_0001;
  localparam logic [31:0] RST_MCK_DIV = 32'h2000_0000;
  localparam logic [3:0]  RST_RATIO   = 4'h6;
  localparam logic [1:0]  RST_SWIDTH  = 2'h1;
  localparam logic [31:0] RST_PIN     = 32'hFFFF_FFFF;

  // role encodings
  localparam logic ROLE_MASTER = 1'b0;
  localparam logic ROLE_SLAVE  = 1'b1;

  // ----------------------------------------------------------------
  // run state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ASCTL_IDLE     = 2'b00,
    ASCTL_RUN      = 2'b01,
    ASCTL_STOPPING = 2'b11
  } asctl_state_t;

endpackage
`default_nettype wire

// *** verilog/asctl_top.sv ***
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module asctl_top (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // interconnect channels
  input  wire logic [15:0] i_chan_trigger,
  output logic      [15:0] o_chan_publish,
  // word strobes from the serial engine
  input  wire logic        i_rx_word_done,
  input  wire logic        i_tx_word_done,
  // pins (oe low = driven)
  input  wire logic [31:0] i_pin_in,
  output logic      [31:0] o_pin_out,
  output logic      [31:0] o_pin_oe_n,
  output logic      [31:0] o_pin_owned,
  // serial engine side
  input  wire logic        i_master_clock_out,
  input  wire logic        i_bit_clock,
  input  wire logic        i_frame_clock,
  input  wire logic        i_serial_output,
  output logic             o_serial_input,
  output logic             o_ext_bit_clock,
  output logic             o_ext_frame_clock,
  output logic             o_running,
  output logic             o_mck_gen_run,
  output logic      [31:0] o_rx_pointer_active,
  output logic      [31:0] o_tx_pointer_active,
  output logic             o_irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] start_link_r, stop_link_r;
  logic [31:0] rx_bcast_r, stop_bcast_r, tx_bcast_r;
  logic [2:0]  flags_r;   // {tx, stopped, rx}
  logic [2:0]  irq_en_r;  // {tx, stopped, rx}
  logic        unit_en_r, role_r, rx_en_r, tx_en_r, mck_en_r;
  logic [31:0] mck_div_r;
  logic [3:0]  ratio_r;
  logic [1:0]  swidth_r;
  logic        align_r, format_r;
  logic [1:0]  channels_r;
  logic [31:0] rx_ptr_r, tx_ptr_r, word_count_r;
  logic [31:0] pin_sel_r [5];  // mck, bck, fck, sin, sout
  logic [31:0] rx_cnt_r, tx_cnt_r;
  asctl_pkg::asctl_state_t state_r;

  logic wr_access, rd_access;
  logic start_trig, stop_trig;
  logic rx_upd, tx_upd, stopped_ev;
  logic [31:0] count_limit;

  assign wr_access = i_psel & i_penable & i_pwrite;
  assign rd_access = i_psel & i_penable & ~i_pwrite;
  assign o_pready  = 1'b1;

  // ----------------------------------------------------------------
  // tasks from bus and channels
  // ----------------------------------------------------------------
  always_comb begin
    start_trig = wr_access && i_paddr == asctl_pkg::OFS_START_TASK && i_pwdata[0];
    stop_trig  = wr_access && i_paddr == asctl_pkg::OFS_STOP_TASK && i_pwdata[0];
    if (start_link_r[asctl_pkg::LINK_EN_BIT] &&
        i_chan_trigger[start_link_r[asctl_pkg::LINK_CH_W-1:0]]) begin
      start_trig = 1'b1;
    end
    if (stop_link_r[asctl_pkg::LINK_EN_BIT] &&
        i_chan_trigger[stop_link_r[asctl_pkg::LINK_CH_W-1:0]]) begin
      stop_trig = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // run state; stop wins over a simultaneous start
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_r <= asctl_pkg::ASCTL_IDLE;
    end else begin
      case (state_r)
        asctl_pkg::ASCTL_IDLE: begin
          if (stop_trig) begin
            state_r <= asctl_pkg::ASCTL_STOPPING;
          end else if (start_trig && unit_en_r) begin
            state_r <= asctl_pkg::ASCTL_RUN;
          end
        end
        asctl_pkg::ASCTL_RUN: begin
          if (stop_trig || !unit_en_r) begin
            state_r <= asctl_pkg::ASCTL_STOPPING;
          end
        end
        asctl_pkg::ASCTL_STOPPING: begin
          state_r <= asctl_pkg::ASCTL_IDLE;
        end
        default: begin
          state_r <= asctl_pkg::ASCTL_IDLE;
        end
      endcase
    end
  end

  assign o_running     = (state_r == asctl_pkg::ASCTL_RUN);
  assign o_mck_gen_run = o_running & mck_en_r;
  // stopped fires once halting is done, one cycle after the stop task
  assign stopped_ev    = (state_r == asctl_pkg::ASCTL_STOPPING);

  // ----------------------------------------------------------------
  // pointer double buffers and word counting
  // ----------------------------------------------------------------
  // a zero word count is treated as one to avoid a stuck counter
  assign count_limit = (word_count_r == 32'h0000_0000) ? 32'h0000_0001 : word_count_r;

  assign rx_upd = o_running & rx_en_r & i_rx_word_done &
                  (rx_cnt_r + 32'h0000_0001 >= count_limit);
  assign tx_upd = o_running & tx_en_r & i_tx_word_done &
                  (tx_cnt_r + 32'h0000_0001 >= count_limit);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rx_cnt_r <= asctl_pkg::RST_ZERO;
      o_rx_pointer_active <= asctl_pkg::RST_ZERO;
    end else if (!o_running || !rx_en_r) begin
      rx_cnt_r <= asctl_pkg::RST_ZERO;
      o_rx_pointer_active <= rx_ptr_r;
    end else if (i_rx_word_done) begin
      if (rx_upd) begin
        rx_cnt_r <= asctl_pkg::RST_ZERO;
        o_rx_pointer_active <= rx_ptr_r;
      end else begin
        rx_cnt_r <= rx_cnt_r + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      tx_cnt_r <= asctl_pkg::RST_ZERO;
      o_tx_pointer_active <= asctl_pkg::RST_ZERO;
    end else if (!o_running || !tx_en_r) begin
      tx_cnt_r <= asctl_pkg::RST_ZERO;
      o_tx_pointer_active <= tx_ptr_r;
    end else if (i_tx_word_done) begin
      if (tx_upd) begin
        tx_cnt_r <= asctl_pkg::RST_ZERO;
        o_tx_pointer_active <= tx_ptr_r;
      end else begin
        tx_cnt_r <= tx_cnt_r + 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // event flags: a set in the same cycle as a clear wins
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      flags_r <= 3'h0;
    end else begin
      if (wr_access && i_paddr == asctl_pkg::OFS_RX_UPD_FLAG) begin
        flags_r[0] <= i_pwdata[0];
      end
      if (wr_access && i_paddr == asctl_pkg::OFS_STOPPED_FLAG) begin
        flags_r[1] <= i_pwdata[0];
      end
      if (wr_access && i_paddr == asctl_pkg::OFS_TX_UPD_FLAG) begin
        flags_r[2] <= i_pwdata[0];
      end
      if (rx_upd) begin
        flags_r[0] <= 1'b1;
      end
      if (stopped_ev) begin
        flags_r[1] <= 1'b1;
      end
      if (tx_upd) begin
        flags_r[2] <= 1'b1;
      end
    end
  end

  assign o_irq = |(flags_r & irq_en_r);

  // ----------------------------------------------------------------
  // event broadcast
  // ----------------------------------------------------------------
  always_comb begin
    o_chan_publish = 16'h0000;
    if (rx_upd && rx_bcast_r[asctl_pkg::LINK_EN_BIT]) begin
      o_chan_publish[rx_bcast_r[asctl_pkg::LINK_CH_W-1:0]] = 1'b1;
    end
    if (stopped_ev && stop_bcast_r[asctl_pkg::LINK_EN_BIT]) begin
      o_chan_publish[stop_bcast_r[asctl_pkg::LINK_CH_W-1:0]] = 1'b1;
    end
    if (tx_upd && tx_bcast_r[asctl_pkg::LINK_EN_BIT]) begin
      o_chan_publish[tx_bcast_r[asctl_pkg::LINK_CH_W-1:0]] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      start_link_r <= asctl_pkg::RST_ZERO;
      stop_link_r  <= asctl_pkg::RST_ZERO;
      rx_bcast_r   <= asctl_pkg::RST_ZERO;
      stop_bcast_r <= asctl_pkg::RST_ZERO;
      tx_bcast_r   <= asctl_pkg::RST_ZERO;
      irq_en_r     <= 3'h0;
      unit_en_r    <= 1'b0;
      role_r       <= asctl_pkg::ROLE_MASTER;
      rx_en_r      <= 1'b0;
      tx_en_r      <= asctl_pkg::RST_TX_EN[0];
      mck_en_r     <= asctl_pkg::RST_TX_EN[0];
      mck_div_r    <= asctl_pkg::RST_MCK_DIV;
      ratio_r      <= asctl_pkg::RST_RATIO;
      swidth_r     <= asctl_pkg::RST_SWIDTH;
      align_r      <= 1'b0;
      format_r     <= 1'b0;
      channels_r   <= 2'h0;
      rx_ptr_r     <= asctl_pkg::RST_ZERO;
      tx_ptr_r     <= asctl_pkg::RST_ZERO;
      word_count_r <= asctl_pkg::RST_ZERO;
      for (int k = 0; k < 5; k++) begin
        pin_sel_r[k] <= asctl_pkg::RST_PIN;
      end
    end else if (wr_access) begin
      case (i_paddr)
        asctl_pkg::OFS_START_LINK:    start_link_r <= i_pwdata & 32'h8000_000F;
        asctl_pkg::OFS_STOP_LINK:     stop_link_r  <= i_pwdata & 32'h8000_000F;
        asctl_pkg::OFS_RX_UPD_BCAST:  rx_bcast_r   <= i_pwdata & 32'h8000_000F;
        asctl_pkg::OFS_STOPPED_BCAST: stop_bcast_r <= i_pwdata & 32'h8000_000F;
        asctl_pkg::OFS_TX_UPD_BCAST:  tx_bcast_r   <= i_pwdata & 32'h8000_000F;
        asctl_pkg::OFS_IRQ_ENABLE: begin
          irq_en_r <= {i_pwdata[asctl_pkg::IRQ_TX_BIT], i_pwdata[asctl_pkg::IRQ_STOP_BIT],
                       i_pwdata[asctl_pkg::IRQ_RX_BIT]};
        end
        asctl_pkg::OFS_IRQ_SET: begin
          irq_en_r <= irq_en_r | {i_pwdata[asctl_pkg::IRQ_TX_BIT],
                      i_pwdata[asctl_pkg::IRQ_STOP_BIT], i_pwdata[asctl_pkg::IRQ_RX_BIT]};
        end
        asctl_pkg::OFS_IRQ_CLEAR: begin
          irq_en_r <= irq_en_r & ~{i_pwdata[asctl_pkg::IRQ_TX_BIT],
                      i_pwdata[asctl_pkg::IRQ_STOP_BIT], i_pwdata[asctl_pkg::IRQ_RX_BIT]};
        end
        asctl_pkg::OFS_UNIT_ENABLE: unit_en_r    <= i_pwdata[0];
        asctl_pkg::OFS_ROLE:        role_r       <= i_pwdata[0];
        asctl_pkg::OFS_RX_ENABLE:   rx_en_r      <= i_pwdata[0];
        asctl_pkg::OFS_TX_ENABLE:   tx_en_r      <= i_pwdata[0];
        asctl_pkg::OFS_MCK_ENABLE:  mck_en_r     <= i_pwdata[0];
        asctl_pkg::OFS_MCK_DIVIDER: mck_div_r    <= i_pwdata;
        asctl_pkg::OFS_RATIO:       ratio_r      <= i_pwdata[3:0];
        asctl_pkg::OFS_SWIDTH:      swidth_r     <= i_pwdata[1:0];
        asctl_pkg::OFS_ALIGN:       align_r      <= i_pwdata[0];
        asctl_pkg::OFS_FORMAT:      format_r     <= i_pwdata[0];
        asctl_pkg::OFS_CHANNELS:    channels_r   <= i_pwdata[1:0];
        asctl_pkg::OFS_RX_PTR:      rx_ptr_r     <= i_pwdata;
        asctl_pkg::OFS_TX_PTR:      tx_ptr_r     <= i_pwdata;
        asctl_pkg::OFS_WORD_COUNT:  word_count_r <= i_pwdata;
        asctl_pkg::OFS_PIN_MCK:     pin_sel_r[0] <= i_pwdata;
        asctl_pkg::OFS_PIN_BCK:     pin_sel_r[1] <= i_pwdata;
        asctl_pkg::OFS_PIN_FCK:     pin_sel_r[2] <= i_pwdata;
        asctl_pkg::OFS_PIN_SIN:     pin_sel_r[3] <= i_pwdata;
        asctl_pkg::OFS_PIN_SOUT:    pin_sel_r[4] <= i_pwdata;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register reads; tasks read zero, unmapped answers slverr
  // ----------------------------------------------------------------
  logic [31:0] rd_data;
  logic        rd_hit;
  logic [31:0] irq_view;

  always_comb begin
    irq_view = 32'h0000_0000;
    irq_view[asctl_pkg::IRQ_RX_BIT]   = irq_en_r[0];
    irq_view[asctl_pkg::IRQ_STOP_BIT] = irq_en_r[1];
    irq_view[asctl_pkg::IRQ_TX_BIT]   = irq_en_r[2];
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;
    case (i_paddr)
      asctl_pkg::OFS_START_TASK:    rd_data = 32'h0000_0000;
      asctl_pkg::OFS_STOP_TASK:     rd_data = 32'h0000_0000;
      asctl_pkg::OFS_START_LINK:    rd_data = start_link_r;
      asctl_pkg::OFS_STOP_LINK:     rd_data = stop_link_r;
      asctl_pkg::OFS_RX_UPD_FLAG:   rd_data = {31'h0, flags_r[0]};
      asctl_pkg::OFS_STOPPED_FLAG:  rd_data = {31'h0, flags_r[1]};
      asctl_pkg::OFS_TX_UPD_FLAG:   rd_data = {31'h0, flags_r[2]};
      asctl_pkg::OFS_RX_UPD_BCAST:  rd_data = rx_bcast_r;
      asctl_pkg::OFS_STOPPED_BCAST: rd_data = stop_bcast_r;
      asctl_pkg::OFS_TX_UPD_BCAST:  rd_data = tx_bcast_r;
      asctl_pkg::OFS_IRQ_ENABLE:    rd_data = irq_view;
      asctl_pkg::OFS_IRQ_SET:       rd_data = irq_view;
      asctl_pkg::OFS_IRQ_CLEAR:     rd_data = irq_view;
      asctl_pkg::OFS_UNIT_ENABLE:   rd_data = {31'h0, unit_en_r};
      asctl_pkg::OFS_ROLE:          rd_data = {31'h0, role_r};
      asctl_pkg::OFS_RX_ENABLE:     rd_data = {31'h0, rx_en_r};
      asctl_pkg::OFS_TX_ENABLE:     rd_data = {31'h0, tx_en_r};
      asctl_pkg::OFS_MCK_ENABLE:    rd_data = {31'h0, mck_en_r};
      asctl_pkg::OFS_MCK_DIVIDER:   rd_data = mck_div_r;
      asctl_pkg::OFS_RATIO:         rd_data = {28'h0, ratio_r};
      asctl_pkg::OFS_SWIDTH:        rd_data = {30'h0, swidth_r};
      asctl_pkg::OFS_ALIGN:         rd_data = {31'h0, align_r};
      asctl_pkg::OFS_FORMAT:        rd_data = {31'h0, format_r};
      asctl_pkg::OFS_CHANNELS:      rd_data = {30'h0, channels_r};
      asctl_pkg::OFS_RX_PTR:        rd_data = rx_ptr_r;
      asctl_pkg::OFS_TX_PTR:        rd_data = tx_ptr_r;
      asctl_pkg::OFS_WORD_COUNT:    rd_data = word_count_r;
      asctl_pkg::OFS_PIN_MCK:       rd_data = pin_sel_r[0];
      asctl_pkg::OFS_PIN_BCK:       rd_data = pin_sel_r[1];
      asctl_pkg::OFS_PIN_FCK:       rd_data = pin_sel_r[2];
      asctl_pkg::OFS_PIN_SIN:       rd_data = pin_sel_r[3];
      asctl_pkg::OFS_PIN_SOUT:      rd_data = pin_sel_r[4];
      default:                      rd_hit  = 1'b0;
    endcase
  end

  assign o_pslverr = i_psel & i_penable & ~rd_hit;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      o_prdata <= rd_data;
    end
  end

  // ----------------------------------------------------------------
  // pin routing and direction
  // ----------------------------------------------------------------
  logic [4:0] sig_out;   // value per signal: mck, bck, fck, sin, sout
  logic [4:0] sig_drv;   // signal drives its pin
  logic [4:0] sig_conn;

  always_comb begin
    // idle outputs sit low when not running
    sig_out = {i_serial_output & o_running, 1'b0,
               i_frame_clock & o_running, i_bit_clock & o_running,
               i_master_clock_out & o_mck_gen_run};
    if (role_r == asctl_pkg::ROLE_MASTER) begin
      sig_drv = 5'b10111;
    end else begin
      sig_drv = 5'b10001;
    end
    for (int k = 0; k < 5; k++) begin
      sig_conn[k] = unit_en_r & ~pin_sel_r[k][asctl_pkg::PIN_CONN_BIT];
    end
    o_pin_out   = 32'h0000_0000;
    o_pin_oe_n  = 32'hFFFF_FFFF;
    o_pin_owned = 32'h0000_0000;
    for (int k = 0; k < 5; k++) begin
      if (sig_conn[k]) begin
        o_pin_owned[pin_sel_r[k][asctl_pkg::PIN_NUM_W-1:0]] = 1'b1;
        if (sig_drv[k]) begin
          o_pin_oe_n[pin_sel_r[k][asctl_pkg::PIN_NUM_W-1:0]] = 1'b0;
          o_pin_out[pin_sel_r[k][asctl_pkg::PIN_NUM_W-1:0]]  = sig_out[k];
        end
      end
    end
    o_serial_input    = sig_conn[3] & i_pin_in[pin_sel_r[3][asctl_pkg::PIN_NUM_W-1:0]];
    o_ext_bit_clock   = sig_conn[1] & ~sig_drv[1] &
                        i_pin_in[pin_sel_r[1][asctl_pkg::PIN_NUM_W-1:0]];
    o_ext_frame_clock = sig_conn[2] & ~sig_drv[2] &
                        i_pin_in[pin_sel_r[2][asctl_pkg::PIN_NUM_W-1:0]];
  end

endmodule

`default_nettype wire

// *** bench/asctl_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module asctl_properties (
  // watched ports
  input wire logic        i_clock,
  input wire logic        i_sys_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [15:0] i_chan_trigger,
  input wire logic        o_pready,
  input wire logic        o_running,
  input wire logic        o_mck_gen_run,
  input wire logic        o_irq,
  input wire logic [31:0] o_pin_out,
  input wire logic [31:0] o_pin_oe_n,
  input wire logic [31:0] o_pin_owned
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  logic wr_acc;
  logic start_req;
  assign wr_acc = i_psel && i_penable && i_pwrite;
  assign start_req = (wr_acc && i_paddr == 12'h000 && i_pwdata[0]) || i_chan_trigger != 16'h0;
  access_ready_a: assert property (
    i_psel && i_penable |-> o_pready) else $error("pready low");
  stop_halts_a: assert property (
    wr_acc && i_paddr == 12'h004 && i_pwdata[0] |=> !o_running) else $error("run after stop");
  start_cause_a: assert property (
    $rose(o_running) |-> $past(start_req)) else $error("run without start");
  gen_gate_a: assert property (
    o_mck_gen_run |-> o_running) else $error("generator while idle");
  idle_low_a: assert property (
    !o_running |-> o_pin_out == 32'h0) else $error("pin high while idle");
  reset_vals_a: assert property (
    $past(i_sys_rst) |-> !o_running && !o_irq && o_pin_owned == 32'h0) else $error("reset state");
  irq_off_a: assert property (
    wr_acc && i_paddr == 12'h300 && i_pwdata == 32'h0 |-> ##2 !o_irq) else $error("irq on");
  own_drive_a: assert property (
    (o_pin_oe_n | o_pin_owned) == 32'hFFFF_FFFF) else $error("unowned pin driven");
  run_seen_c: cover property ($rose(o_running));
  stop_seen_c: cover property ($fell(o_running));
  irq_seen_c: cover property (o_irq);
endmodule
bind asctl_top asctl_properties chk_u (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .i_chan_trigger(i_chan_trigger), .o_pready(o_pready), .o_running(o_running),
  .o_mck_gen_run(o_mck_gen_run), .o_irq(o_irq), .o_pin_out(o_pin_out),
  .o_pin_oe_n(o_pin_oe_n), .o_pin_owned(o_pin_owned));
`default_nettype wire

// *** bench/asctl_codec.sv ***
`timescale 1ns/100ps
`default_nettype none
module asctl_codec (
  // pin side
  input  wire logic        i_clock,
  input  wire logic [31:0] i_pin_out,
  input  wire logic [31:0] i_pin_oe_n,
  output logic      [31:0] o_pin_lvl
);
  logic [31:0] pat_r = 32'h0000_0001;
  // undriven pins follow a shifting pattern in which one pin changes each cycle
  always_ff @(posedge i_clock) begin
    pat_r <= {pat_r[30:0], ~pat_r[31]};
  end
  assign o_pin_lvl = (~i_pin_oe_n & i_pin_out) | (i_pin_oe_n & pat_r);
endmodule
`default_nettype wire

// *** bench/audio_serial_task_event_pin_control_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module audio_serial_task_event_pin_control_tb_top;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, rxw = 1'b0;
  logic        txw = 1'b0, rdy, err, slverr, irq, run, ebck, sin, efck, mgr;
  logic [11:0] addr = 12'h0;
  logic [15:0] trig = 16'h0, pub, got;
  logic [31:0] wdat = 32'h0, seed = 32'hDF65, prd, rdat, lvl, pout, oen, own, rxp, txp, optr;
  logic [3:0]  sig = 4'h0;
  int          n_errors = 0, checks_done = 0, cyc = 0;
  int          mdl [int] = '{12'h50C: 32'h1, 12'h510: 32'h1, 12'h514: 32'h2000_0000,
                 12'h518: 32'h6, 12'h51C: 32'h1, 12'h564: 32'hFFFF_FFFF, 12'h300: 32'h0};
  asctl_top dut_u (.i_clock(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdat), .o_prdata(prd), .o_pready(rdy),
    .o_pslverr(slverr), .i_chan_trigger(trig), .o_chan_publish(pub), .i_rx_word_done(rxw),
    .i_tx_word_done(txw), .i_pin_in(lvl), .o_pin_out(pout), .o_pin_oe_n(oen),
    .o_pin_owned(own), .i_master_clock_out(sig[0]), .i_bit_clock(sig[1]),
    .i_frame_clock(sig[2]), .i_serial_output(sig[3]), .o_serial_input(sin),
    .o_ext_bit_clock(ebck), .o_ext_frame_clock(efck), .o_running(run), .o_mck_gen_run(mgr),
    .o_rx_pointer_active(rxp), .o_tx_pointer_active(txp), .o_irq(irq));
  asctl_codec codec_u (.i_clock(clk), .i_pin_out(pout), .i_pin_oe_n(oen), .o_pin_lvl(lvl));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic test_done();
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdat <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    rdat = prd;
    err = slverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    mdl[a] = d;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    cmp($sformatf("reg %h", a), e, rdat);
  endtask
  always #4 clk = ~clk;
  // random levels on the engine side; hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    seed <= lfsr(seed);
    sig <= seed[3:0];
    if (cyc == 5000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (mdl[a]) rd(a[11:0], mdl[a]);
    wr(12'h540, seed);
    wr(12'h538, lfsr(seed));
    wr(12'h550, 32'h2);
    wr(12'h508, 32'h1);
    for (int p = 0; p < 5; p++) wr(12'h560 + 12'(4 * p), 32'(p));
    wr(12'h500, 32'h1);
    @(negedge clk);
    cmp("owned", 32'h1F, own);
    cmp("oe_n master", ~32'h17, oen);
    cmp("serial in", {31'h0, lvl[3]}, {31'h0, sin});
    wr(12'h000, 32'h1);
    @(negedge clk);
    cmp("run", 32'h1, {31'h0, run});
    cmp("generator", 32'h1, {31'h0, mgr});
    cmp("pins", {30'h0, sig[3], sig[0]}, {30'h0, pout[4], pout[0]});
    // a pointer written while running waits for the next update
    optr = mdl[12'h540];
    wr(12'h540, ~seed);
    cmp("tx ptr held", optr, txp);
    for (int k = 1; k <= 2; k++) begin
      @(posedge clk);
      txw <= 1'b1;
      rxw <= 1'b1;
      @(posedge clk);
      txw <= 1'b0;
      rxw <= 1'b0;
      rd(12'h114, 32'(k == 2));
      rd(12'h104, 32'(k == 2));
    end
    cmp("tx ptr", mdl[12'h540], txp);
    cmp("rx ptr", mdl[12'h538], rxp);
    wr(12'h304, 32'h20);
    repeat (2) @(negedge clk);
    cmp("irq", 32'h1, {31'h0, irq});
    wr(12'h114, 32'h0);
    repeat (2) @(negedge clk);
    cmp("irq", 32'h0, {31'h0, irq});
    rd(12'h308, 32'h20);
    wr(12'h304, 32'h2);
    @(negedge clk);
    cmp("irq rx", 32'h1, {31'h0, irq});
    wr(12'h300, 32'h0);
    @(negedge clk);
    cmp("irq off", 32'h0, {31'h0, irq});
    wr(12'h104, 32'h0);
    wr(12'h084, 32'h8000_0003);
    wr(12'h188, 32'h8000_0007);
    @(posedge clk);
    trig <= 16'h0008;
    @(posedge clk);
    trig <= 16'h0000;
    got = 16'h0;
    repeat (4) @(negedge clk) got |= pub;
    cmp("publish", 32'h80, {16'h0, got});
    cmp("run", 32'h0, {31'h0, run});
    cmp("generator", 32'h0, {31'h0, mgr});
    rd(12'h108, 32'h1);
    wr(12'h504, 32'h1);
    @(negedge clk);
    cmp("oe_n slave", ~32'h11, oen);
    cmp("bit clock in", {31'h0, lvl[1]}, {31'h0, ebck});
    cmp("frame clock in", {31'h0, lvl[2]}, {31'h0, efck});
    wr(12'h500, 32'h0);
    @(negedge clk);
    cmp("owned", 32'h0, own);
    xfer(1'b0, 12'h7FC, 32'h0);
    cmp("slverr", 32'h1, {31'h0, err});
    wr(12'h300, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
